// ===== core/vfsc_pkg.sv
package vfsc_pkg;

	// ==================== register map ====================
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_GAIN    = 8'h04;
	localparam logic [7:0] OFF_CHROMA  = 8'h08;
	localparam logic [7:0] OFF_PED     = 8'h0C;
	localparam logic [7:0] OFF_HUE     = 8'h10;
	localparam logic [7:0] OFF_TRIM    = 8'h14;
	localparam logic [7:0] OFF_TIMING  = 8'h18;
	localparam logic [7:0] OFF_DEFAULT = 8'h1C;
	localparam logic [7:0] OFF_STATUS  = 8'h20;

	// ==================== nominal values ====================
	localparam logic [7:0] GAIN_NOM  = 8'h64;
	localparam logic [7:0] GAIN_MIN  = 8'h32;
	localparam logic [7:0] GAIN_MAX  = 8'h96;
	localparam logic [7:0] PED_LIM   = 8'h05;
	localparam logic [7:0] HUE_LIM   = 8'h5A;
	localparam logic [7:0] TRIM_LIM  = 8'h1E;
	localparam logic [10:0] VOFF_LIM = 11'h271;
	localparam logic [11:0] HOFF_LIM = 12'h6B3;

	// ==================== blanking ends ====================
	localparam logic [9:0] BLK_WIDE_625   = 10'h016;
	localparam logic [9:0] BLK_WIDE_525   = 10'h014;
	localparam logic [9:0] BLK_NARROW_625 = 10'h006;
	localparam logic [9:0] BLK_NARROW_525 = 10'h009;

	// ==================== timing ====================
	localparam int CLK_HZ       = 27_000_000;
	localparam int BLINK_SEC    = 15;
	localparam int BLINK_CYCLES = CLK_HZ * BLINK_SEC;

	typedef enum logic [2:0] {
		SRC_CPST = 3'h0, SRC_YC = 3'h1, SRC_BETA = 3'h2, SRC_SMPTE = 3'h3,
		SRC_SDI = 3'h4, SRC_BARS = 3'h5, SRC_CHECK = 3'h6
	} vfsc_src_t;

	typedef enum logic [1:0] {
		MUTE_NONE = 2'h0, MUTE_BLACK = 2'h1, MUTE_FREEZE = 2'h2
	} vfsc_mute_t;

	typedef enum logic [2:0] {
		SEL_SYNC = 3'b001, SEL_GAIN = 3'b010, SEL_SRC = 3'b100
	} vfsc_sel_t;

	typedef struct packed {
		logic left;
		logic right;
		logic mode;
	} vfsc_btn_t;

	typedef struct packed {
		logic [7:0]  gain;
		logic [7:0]  chroma;
		logic [7:0]  pedestal;
		logic [7:0]  hue;
		logic [7:0]  redGain;
		logic [7:0]  blueGain;
		logic [7:0]  redOffset;
		logic [7:0]  blueOffset;
		logic [10:0] vOffset;
		logic [11:0] hOffset;
	} vfsc_proc_t;

endpackage : vfsc_pkg

// ===== core/vfsc_btn_edge.sv
`timescale 1ns/1ps
// ==================== button press detection ====================
module vfsc_btn_edge
	import vfsc_pkg::*;
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// buttons
	input  wire vfsc_btn_t btnLevel,
	output      vfsc_btn_t btnPress,
	output      logic      bothHeld
);
	vfsc_btn_t prev_reg;

	always_ff @(posedge clk) begin
		if (rst)
			prev_reg <= '0;
		else
			prev_reg <= btnLevel;
	end

	// a press is the rising edge of the level
	assign btnPress = btnLevel & ~prev_reg;
	assign bothHeld = btnLevel.left & btnLevel.right &
		(btnPress.left | btnPress.right);
endmodule : vfsc_btn_edge

// ===== core/vfsc_blink_timer.sv
`timescale 1ns/1ps
// ==================== edit blink timeout ====================
module vfsc_blink_timer #(
	parameter int CYCLES = 405_000_000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic restart,
	output      logic running,
	output      logic expired
);
	logic [31:0] count_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= 32'h0000_0000;
			expired   <= 1'b0;
		end else if (restart) begin
			count_reg <= 32'(CYCLES);
			expired   <= 1'b0;
		end else if (count_reg != 32'h0000_0000) begin
			count_reg <= count_reg - 32'h0000_0001;
			expired   <= (count_reg == 32'h0000_0001);
		end else begin
			expired <= 1'b0;
		end
	end

	assign running = (count_reg != 32'h0000_0000);
endmodule : vfsc_blink_timer

// ===== core/vfsc_core.sv
`timescale 1ns/1ps
// Summary of operation
// - arrows turn synchronizer off/on; green when on
// - arrows step gain while gain selected
// - gain indicator green at unity, else red
// - both arrows together restore unity gain
// - route exactly one of seven sources
// - comb filter three-line or five-line
// - setup removal only when on and 525
// - no muting passes input untouched
// - black output while input lost
// - freeze last frame while input lost
// - report input presence, rate, reference presence
// - gain 50 to 150 percent
// - chroma 50 to 150 percent, software only
// - pedestal within plus/minus five IRE
// - hue plus/minus ninety, 525 only
// - default command restores nominal setting
// - component trims gain and offset per channel
// - timing offsets only while synchronizer on
// - vertical offset up to 625 lines
// - horizontal offset up to 1715 clocks
// - wide or narrow vertical blanking lines
// - blink fifteen seconds then commit value
// - input lamp dark for internal patterns
module vfsc_core
	import vfsc_pkg::*;
#(
	parameter int BLINK_CNT = BLINK_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// front panel
	input  wire vfsc_btn_t   buttons,
	output      logic        syncLedGreen,
	output      logic        gainLedGreen,
	output      logic        gainLedRed,
	output      logic        inputLed,
	output      logic        refLed,
	output      logic [6:0]  sourceLeds,
	output      logic        blinkLed,
	// video status
	input  wire logic        frameStart,
	input  wire logic [9:0]  lineNumber,
	input  wire logic        inputPresent,
	input  wire logic        input625,
	input  wire logic        refPresent,
	// processing settings
	output      vfsc_proc_t  procActive,
	output      logic [2:0]  sourceSel,
	output      logic        combFiveLine,
	output      logic        setupRemove,
	output      logic        hueApply,
	output      logic        trimApply,
	output      logic        syncEnable,
	output      logic        timingFromRef,
	output      logic        muteBlack,
	output      logic        muteFreeze,
	output      logic        vBlankActive,
	output      logic        commitStrobe
);
	// ==================== state ====================
	vfsc_proc_t  set_reg;
	logic [2:0]  src_reg;
	logic        comb_reg;
	logic        setup_reg;
	vfsc_mute_t  mute_reg;
	logic        wide_reg;
	logic        sync_reg;
	vfsc_sel_t   sel_reg;
	vfsc_btn_t   press;
	logic        both;
	logic        edit;
	logic        blinking;
	logic        expired;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [9:0]  blkEnd;
	logic        is625;

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign mapped = (paddr <= OFF_STATUS) && (paddr[1:0] == 2'b00);
	assign is625 = input625;

	vfsc_btn_edge u_btn (
		.clk      (clk),
		.rst      (rst),
		.btnLevel (buttons),
		.btnPress (press),
		.bothHeld (both)
	);

	vfsc_blink_timer #(.CYCLES(BLINK_CNT)) u_blink (
		.clk     (clk),
		.rst     (rst),
		.restart (edit),
		.running (blinking),
		.expired (expired)
	);

	assign edit = press.left | press.right | press.mode;

	// ==================== panel selection ====================
	always_ff @(posedge clk) begin
		if (rst)
			sel_reg <= SEL_SYNC;
		else if (press.mode)
			case (sel_reg)
				SEL_SYNC: sel_reg <= SEL_GAIN;
				SEL_GAIN: sel_reg <= SEL_SRC;
				SEL_SRC:  sel_reg <= SEL_SYNC;
				default:  sel_reg <= SEL_SYNC;
			endcase
	end

	// ==================== synchronizer enable ====================
	// a panel press and a bus write in one cycle: the press wins
	always_ff @(posedge clk) begin
		if (rst)
			sync_reg <= 1'b1;
		else if (sel_reg == SEL_SYNC && press.left)
			sync_reg <= 1'b0;
		else if (sel_reg == SEL_SYNC && press.right)
			sync_reg <= 1'b1;
		else if (wr && paddr == OFF_CTRL)
			sync_reg <= pwdata[8];
	end

	// ==================== source, comb, setup, mute, blanking ====================
	always_ff @(posedge clk) begin
		if (rst) begin
			src_reg   <= SRC_CPST;
			comb_reg  <= 1'b0;
			setup_reg <= 1'b0;
			mute_reg  <= MUTE_NONE;
			wide_reg  <= 1'b1;
		end else begin
			if (wr && paddr == OFF_CTRL) begin
				// out-of-range source codes are ignored so one source always stands
				if (pwdata[2:0] <= SRC_CHECK)
					src_reg <= pwdata[2:0];
				comb_reg  <= pwdata[3];
				setup_reg <= pwdata[4];
				if (pwdata[6:5] != 2'b11)
					mute_reg <= vfsc_mute_t'(pwdata[6:5]);
				wide_reg  <= pwdata[7];
			end
			// the panel step is scheduled last so a press beats a bus write
			if (sel_reg == SEL_SRC && press.right)
				src_reg <= (src_reg == SRC_CHECK) ? SRC_CPST : src_reg + 3'h1;
			else if (sel_reg == SEL_SRC && press.left)
				src_reg <= (src_reg == SRC_CPST) ? SRC_CHECK : src_reg - 3'h1;
		end
	end

	// ==================== processing settings ====================
	// bus gain, chroma, pedestal, hue and trim gains saturate at their limits; out-of-range timing offsets are ignored
	function automatic logic [7:0] clampS(input logic [7:0] v, input logic [7:0] lim);
		logic signed [7:0] s;
		s = signed'(v);
		if (s > signed'(lim))
			clampS = lim;
		else if (s < -signed'(lim))
			clampS = 8'(-lim);
		else
			clampS = v;
	endfunction : clampS

	function automatic logic [7:0] clampU(input logic [7:0] v);
		if (v < GAIN_MIN)
			clampU = GAIN_MIN;
		else if (v > GAIN_MAX)
			clampU = GAIN_MAX;
		else
			clampU = v;
	endfunction : clampU

	always_ff @(posedge clk) begin
		if (rst) begin
			set_reg        <= '0;
			set_reg.gain   <= GAIN_NOM;
			set_reg.chroma <= GAIN_NOM;
		end else if (both) begin
			set_reg.gain <= GAIN_NOM;
		end else if (sel_reg == SEL_GAIN && press.right) begin
			if (set_reg.gain < GAIN_MAX)
				set_reg.gain <= set_reg.gain + 8'h01;
		end else if (sel_reg == SEL_GAIN && press.left) begin
			if (set_reg.gain > GAIN_MIN)
				set_reg.gain <= set_reg.gain - 8'h01;
		end else if (wr) begin
			case (paddr)
				OFF_GAIN:   set_reg.gain   <= clampU(pwdata[7:0]);
				OFF_CHROMA: set_reg.chroma <= clampU(pwdata[7:0]);
				OFF_PED:    set_reg.pedestal <= clampS(pwdata[7:0], PED_LIM);
				OFF_HUE:    set_reg.hue <= clampS(pwdata[7:0], HUE_LIM);
				OFF_TRIM: begin
					set_reg.redGain    <= clampS(pwdata[7:0], TRIM_LIM);
					set_reg.blueGain   <= clampS(pwdata[15:8], TRIM_LIM);
					set_reg.redOffset  <= pwdata[23:16];
					set_reg.blueOffset <= pwdata[31:24];
				end
				OFF_TIMING: begin
					if (pwdata[10:0] <= VOFF_LIM || pwdata[10:0] >= 11'(-VOFF_LIM))
						set_reg.vOffset <= pwdata[10:0];
					if (pwdata[27:16] <= HOFF_LIM || pwdata[27:16] >= 12'(-HOFF_LIM))
						set_reg.hOffset <= pwdata[27:16];
				end
				OFF_DEFAULT: begin
					if (pwdata[0]) set_reg.gain <= GAIN_NOM;
					if (pwdata[1]) set_reg.chroma <= GAIN_NOM;
					if (pwdata[2]) set_reg.pedestal <= 8'h00;
					if (pwdata[3]) set_reg.hue <= 8'h00;
				end
				default: ;
			endcase
		end
	end

	// ==================== frame boundary transfer ====================
	always_ff @(posedge clk) begin
		if (rst) begin
			procActive        <= '0;
			procActive.gain   <= GAIN_NOM;
			procActive.chroma <= GAIN_NOM;
			setupRemove       <= 1'b0;
			hueApply          <= 1'b0;
			trimApply         <= 1'b0;
			combFiveLine      <= 1'b0;
			sourceSel         <= SRC_CPST;
			syncEnable        <= 1'b1;
			timingFromRef     <= 1'b1;
		end else if (frameStart) begin
			procActive    <= set_reg;
			// free running output has no reference to offset against
			if (!sync_reg) begin
				procActive.vOffset <= 11'h000;
				procActive.hOffset <= 12'h000;
			end
			setupRemove   <= setup_reg & ~is625;
			hueApply      <= ~is625;
			trimApply     <= (src_reg == SRC_BETA) | (src_reg == SRC_SMPTE);
			combFiveLine  <= comb_reg;
			sourceSel     <= src_reg;
			syncEnable    <= sync_reg;
			timingFromRef <= sync_reg;
		end
	end

	// ==================== muting ====================
	// muting reacts at once: waiting for a frame edge would show a broken picture
	always_ff @(posedge clk) begin
		if (rst) begin
			muteBlack  <= 1'b0;
			muteFreeze <= 1'b0;
		end else begin
			muteBlack  <= (mute_reg == MUTE_BLACK) & ~inputPresent;
			muteFreeze <= (mute_reg == MUTE_FREEZE) & ~inputPresent;
		end
	end

	// ==================== blanking ====================
	always_comb begin
		if (wide_reg)
			blkEnd = is625 ? BLK_WIDE_625 : BLK_WIDE_525;
		else
			blkEnd = is625 ? BLK_NARROW_625 : BLK_NARROW_525;
	end

	always_ff @(posedge clk) begin
		if (rst)
			vBlankActive <= 1'b0;
		else
			vBlankActive <= (lineNumber != 10'h000) && (lineNumber <= blkEnd);
	end

	// ==================== indicators ====================
	always_ff @(posedge clk) begin
		if (rst) begin
			syncLedGreen <= 1'b0;
			gainLedGreen <= 1'b0;
			gainLedRed   <= 1'b0;
			inputLed     <= 1'b0;
			refLed       <= 1'b0;
			sourceLeds   <= 7'h00;
			blinkLed     <= 1'b0;
			commitStrobe <= 1'b0;
		end else begin
			syncLedGreen <= sync_reg;
			// the gain lamp follows the pending value so an edit shows at once
			gainLedGreen <= (set_reg.gain == GAIN_NOM);
			gainLedRed   <= (set_reg.gain != GAIN_NOM);
			inputLed     <= inputPresent && (src_reg != SRC_BARS) &&
				(src_reg != SRC_CHECK);
			refLed       <= refPresent;
			sourceLeds   <= 7'(7'h01 << src_reg);
			blinkLed     <= blinking;
			commitStrobe <= expired;
		end
	end

	// ==================== apb read ====================
	// read data is latched in the setup cycle so it stands through the access cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (rd)
				case (paddr)
					OFF_CTRL: prdata <= {23'h00_0000, sync_reg, wide_reg,
						mute_reg, setup_reg, comb_reg, src_reg};
					OFF_GAIN:   prdata <= {24'h00_0000, set_reg.gain};
					OFF_CHROMA: prdata <= {24'h00_0000, set_reg.chroma};
					OFF_PED:    prdata <= {24'h00_0000, set_reg.pedestal};
					OFF_HUE:    prdata <= {24'h00_0000, set_reg.hue};
					OFF_TRIM: prdata <= {set_reg.blueOffset, set_reg.redOffset,
						set_reg.blueGain, set_reg.redGain};
					OFF_TIMING: prdata <= {4'h0, set_reg.hOffset, 5'h00, set_reg.vOffset};
					OFF_STATUS: prdata <= {28'h000_0000, blinking, refPresent,
						input625, inputPresent};
					default: prdata <= 32'h0000_0000;
				endcase
		end
	end
endmodule : vfsc_core

// ===== sim/vfsc_core_sva.sv
`timescale 1ns/1ps
module vfsc_core_sva
	import vfsc_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// watched ports
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       gainLedGreen,
	input wire logic       gainLedRed,
	input wire logic       inputLed,
	input wire logic [6:0] sourceLeds,
	input wire logic       frameStart,
	input wire logic       inputPresent,
	input wire logic       input625,
	input wire vfsc_proc_t procActive,
	input wire logic [2:0] sourceSel,
	input wire logic       setupRemove,
	input wire logic       syncEnable,
	input wire logic       muteBlack,
	input wire logic       muteFreeze
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==================== assertions ====================
	chk_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no answer in access");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_gain_leds: assert property (!(gainLedGreen && gainLedRed))
		else $error("gain lamp both colours");
	chk_sync_offsets: assert property (!syncEnable |-> procActive.vOffset == 11'h000)
		else $error("offset while sync off");
	chk_setup_std: assert property ($rose(setupRemove) |-> $past(frameStart) && !$past(input625))
		else $error("setup removal in 625");
	chk_frame_src: assert property ($changed(sourceSel) |-> $past(frameStart))
		else $error("source changed mid frame");
	chk_mute_cause: assert property (muteBlack || muteFreeze |-> !$past(inputPresent))
		else $error("mute with input present");
	chk_pattern_dark: assert property (sourceLeds[5] || sourceLeds[6] |-> !inputLed)
		else $error("input lamp on pattern");
	chk_src_onehot: assert property ($onehot0(sourceLeds))
		else $error("source lamps not one-hot");
endmodule : vfsc_core_sva

bind vfsc_core vfsc_core_sva vfsc_core_sva_inst (.clk, .rst, .psel, .penable, .pready,
	.pslverr, .gainLedGreen, .gainLedRed, .inputLed, .sourceLeds, .frameStart, .inputPresent,
	.input625, .procActive, .sourceSel, .setupRemove, .syncEnable, .muteBlack, .muteFreeze);

// ===== sim/vfsc_video_src.sv
`timescale 1ns/1ps
// short frames keep the run small; lines keep running whether or not input or reference is present
module vfsc_video_src #(
	parameter int LINES     = 30,
	parameter int LINE_CLKS = 2
) (
	// clock and reset
	input wire logic  clk,
	input wire logic  rst,
	// bench controls
	input wire logic  linkUp,
	input wire logic  std625,
	input wire logic  refUp,
	// video status
	output logic       frameStart,
	output logic [9:0] lineNumber,
	output logic       inputPresent,
	output logic       input625,
	output logic       refPresent
);
	int clkCnt;
	always_ff @(posedge clk) begin
		if (rst) begin
			clkCnt <= 0;
			lineNumber <= 10'h001;
		end else if (clkCnt == LINE_CLKS - 1) begin
			clkCnt <= 0;
			lineNumber <= (int'(lineNumber) == LINES) ? 10'h001 : lineNumber + 10'h001;
		end else begin
			clkCnt <= clkCnt + 1;
		end
	end
	assign frameStart = !rst && clkCnt == 0 && lineNumber == 10'h001;
	assign inputPresent = linkUp;
	assign input625 = std625;
	assign refPresent = refUp;
endmodule : vfsc_video_src

// ===== sim/tb_vfsc_core.sv
`timescale 1ns/1ps
module tb_vfsc_core
	import vfsc_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	vfsc_btn_t buttons = 3'h0;
	logic linkUp = 1'b1, std625 = 1'b0, refUp = 1'b1;
	logic pready, pslverr, syncLedGreen, gainLedGreen, gainLedRed, inputLed, refLed, blinkLed;
	logic frameStart, inputPresent, input625, refPresent, combFiveLine, setupRemove, syncEnable;
	logic timingFromRef, muteBlack, muteFreeze, vBlankActive, commitStrobe;
	logic hueApply, trimApply;
	logic [6:0] sourceLeds;
	logic [9:0] lineNumber;
	logic [2:0] sourceSel;
	vfsc_proc_t procActive;
	int failCount = 0, checks = 0, seed = 32'h0000_3DE4;
	logic [7:0] ta[6] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h10};
	logic [31:0] tv[6] = '{32'h0000_0020, 32'h0000_00FF, 32'h0000_0010, 32'h0000_00A0,
		32'h0000_0005, 32'h0000_005A};

	vfsc_video_src vfsc_video_src_inst (.clk, .rst, .linkUp, .std625, .refUp, .frameStart,
		.lineNumber, .inputPresent, .input625, .refPresent);
	vfsc_core #(.BLINK_CNT(20)) vfsc_core_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .buttons, .syncLedGreen, .gainLedGreen,
		.gainLedRed, .inputLed, .refLed, .sourceLeds, .blinkLed, .frameStart, .lineNumber,
		.inputPresent, .input625, .refPresent, .procActive, .sourceSel, .combFiveLine,
		.setupRemove, .hueApply, .trimApply, .syncEnable, .timingFromRef, .muteBlack,
		.muteFreeze, .vBlankActive, .commitStrobe);

	initial forever #50 clk = ~clk;

	task automatic closeOut();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : closeOut

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			failCount++;
			closeOut();
		end
		@(posedge clk);
	endtask : apbXfer

	task automatic wrReg(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] rd;
		logic e;
		apbXfer(1'b1, a, wd, rd, e);
	endtask : wrReg

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] rd;
		logic e;
		apbXfer(1'b0, a, 32'h0000_0000, rd, e);
		cmp(rd, exp, "read");
		cmp(32'(e), 32'(expErr), "slverr");
	endtask : rdChk

	task automatic waitFrame();
		int n;
		n = 0;
		while (frameStart !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			failCount++;
			closeOut();
		end
		repeat (2) @(posedge clk);
	endtask : waitFrame

	task automatic press(input logic [2:0] b);
		buttons <= b;
		repeat (2) @(posedge clk);
		buttons <= 3'h0;
		repeat (3) @(posedge clk);
	endtask : press

	// bench model: clamped gain and chroma, blanking line ends
	function automatic logic [31:0] clamp(input logic [31:0] v);
		return (v < 32'h0000_0032) ? 32'h0000_0032 : (v > 32'h0000_0096) ? 32'h0000_0096 : v;
	endfunction : clamp

	initial begin
		int g, n, prev, last;
		logic [31:0] d;
		logic e;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdChk(OFF_CHROMA, 32'h0000_0064, 1'b0);
		for (int i = 0; i < 6; i++) begin
			wrReg(ta[i], tv[i]);
			rdChk(ta[i], (i < 4) ? clamp(tv[i]) : tv[i], 1'b0);
		end
		repeat (4) begin
			g = 50 + (($random(seed) & 32'h7FFF_FFFF) % 101);
			wrReg(OFF_GAIN, 32'(g));
			rdChk(OFF_GAIN, 32'(g), 1'b0);
		end
		wrReg(OFF_DEFAULT, 32'h0000_000F);
		rdChk(OFF_GAIN, 32'h0000_0064, 1'b0);
		rdChk(OFF_HUE, 32'h0000_0000, 1'b0);
		wrReg(OFF_PED, 32'h0000_00F9);
		rdChk(OFF_PED, 32'h0000_00FB, 1'b0);
		wrReg(OFF_HUE, 32'h0000_00A0);
		rdChk(OFF_HUE, 32'h0000_00A6, 1'b0);
		wrReg(OFF_TRIM, 32'hF00F_E01F);
		rdChk(OFF_TRIM, 32'hF00F_E21E, 1'b0);
		rdChk(8'h40, 32'h0000_0000, 1'b1);
		$display("register test done");
		for (int s = 0; s < 7; s++) begin
			std625 <= s[0];
			wrReg(OFF_CTRL, 32'h0000_0110 | 32'(s) | 32'(s[1]) << 3);
			waitFrame();
			cmp(32'(sourceSel), 32'(s), "source");
			cmp(32'(sourceLeds), 32'h0000_0001 << s, "lamps");
			cmp(32'(inputLed), 32'(s < 5), "input lamp");
			cmp(32'(combFiveLine), 32'(s[1]), "comb");
			cmp(32'(setupRemove), 32'(!s[0]), "setup");
			cmp(32'(hueApply), 32'(!s[0]), "hue std");
			cmp(32'(trimApply), 32'(s == 2 || s == 3), "trims");
		end
		refUp <= 1'b0;
		repeat (2) @(posedge clk);
		cmp(32'(refLed), 32'h0000_0000, "ref lamp");
		apbXfer(1'b0, OFF_STATUS, 32'h0000_0000, d, e);
		cmp(d & 32'h0000_0007, 32'h0000_0001, "status");
		refUp <= 1'b1;
		repeat (2) @(posedge clk);
		cmp(32'(refLed), 32'h0000_0001, "ref lamp");
		$display("source test done");
		for (int m = 0; m < 3; m++) begin
			wrReg(OFF_CTRL, 32'h0000_0100 | 32'(m) << 5);
			waitFrame();
			linkUp <= 1'b0;
			repeat (3) @(posedge clk);
			cmp(32'(muteBlack), 32'(m == 1), "black");
			cmp(32'(muteFreeze), 32'(m == 2), "freeze");
			linkUp <= 1'b1;
			repeat (3) @(posedge clk);
		end
		for (int k = 0; k < 4; k++) begin
			std625 <= k[0];
			wrReg(OFF_CTRL, 32'h0000_0100 | 32'(k[1]) << 7);
			waitFrame();
			last = k[1] ? (k[0] ? 22 : 20) : (k[0] ? 6 : 9);
			prev = int'(lineNumber);
			repeat (64) begin
				@(posedge clk);
				cmp(32'(vBlankActive), 32'(prev >= 1 && prev <= last), "blank");
				prev = int'(lineNumber);
			end
		end
		$display("mute and blanking test done");
		wrReg(OFF_TIMING, 32'h094D_078F);
		waitFrame();
		cmp(32'(procActive.vOffset), 32'h0000_078F, "voff");
		cmp(32'(procActive.hOffset), 32'h0000_094D, "hoff");
		cmp(32'(procActive.hue), 32'h0000_00A6, "hue frame");
		d = 32'h0000_0064;
		for (int k = 0; k < 3 && d === 32'h0000_0064; k++) begin
			press(3'b001);
			press(3'b010);
			apbXfer(1'b0, OFF_GAIN, 32'h0000_0000, d, e);
		end
		cmp(32'(d > 32'h0000_0064), 32'h0000_0001, "gain up");
		cmp(32'({gainLedGreen, gainLedRed}), 32'h0000_0001, "red");
		press(3'b100);
		rdChk(OFF_GAIN, 32'h0000_0064, 1'b0);
		press(3'b010);
		press(3'b110);
		cmp(32'(blinkLed), 32'h0000_0001, "blink");
		rdChk(OFF_GAIN, 32'h0000_0064, 1'b0);
		cmp(32'({gainLedGreen, gainLedRed}), 32'h0000_0002, "green");
		n = 0;
		while (commitStrobe !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		cmp(32'(n < 60), 32'h0000_0001, "commit");
		if (n >= 60) closeOut();
		press(3'b001);
		press(3'b010);
		rdChk(OFF_CTRL, 32'h0000_0181, 1'b0);
		press(3'b001);
		press(3'b100);
		waitFrame();
		cmp(32'({syncEnable, syncLedGreen, timingFromRef}), 32'h0000_0000, "sync off");
		cmp(32'(procActive.hOffset), 32'h0000_0000, "hoff off");
		press(3'b010);
		waitFrame();
		cmp(32'({syncEnable, syncLedGreen, timingFromRef}), 32'h0000_0007, "sync on");
		cmp(32'(procActive.vOffset), 32'h0000_078F, "voff on");
		$display("panel test done");
		wrReg(OFF_GAIN, 32'h0000_0080);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdChk(OFF_GAIN, 32'h0000_0064, 1'b0);
		$display("reset test done");
		closeOut();
	end
endmodule : tb_vfsc_core
